// ---- pss_host_seq.sv ----
// host end: drives supplies, core enable and hard reset in order
`timescale 1ns/100ps
module pss_host_seq #(
	parameter int unsigned SETTLE_CYC = pss_pkg::XO_SETTLE_CYC
) (
	input  wire logic ref_clk_in,   // system clock
	input  wire logic rst_b_in,     // sync reset, low
	input  wire logic power_on_in,  // request power up, level
	output logic      running_out,  // device out of reset
	pss_link_if.host  link          // link to the device
);
	pss_pkg::pss_host_state_t state_ff;
	pss_pkg::pss_host_state_t nxt_state;
	logic batt_ff;
	logic io_ff;
	logic en_ff;
	logic rstl_ff;
	logic run_ff;
	logic nxt_batt;
	logic nxt_io;
	logic nxt_en;
	logic nxt_rstl;
	logic nxt_run;
	logic tmr_start;
	logic tmr_done;

	// one set of link levels, kept as named fields
	typedef struct packed {
		logic batt;   // battery rail on
		logic io;     // io rail on
		logic en;     // core enable high
		logic rstl;   // hard reset released
	} pss_lvl_t;

	pss_lvl_t raw_lvl;   // levels chosen by the sequencer
	pss_lvl_t grd_lvl;   // levels after the order clamp

	// settle timer for the crystal oscillator
	pss_delay_timer #(
		.WIDTH (pss_pkg::CNT_WIDTH)
	) u_settle (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.start_in   (tmr_start),
		.load_in    (pss_pkg::CNT_WIDTH'(SETTLE_CYC)),
		.done_out   (tmr_done)
	);

	// clamp a level set to the legal power order
	// a rail or enable may only stand on the one below it,
	// so a slip in the state decode can never power the core
	// ahead of its supplies or release reset on a dead core
	function automatic pss_lvl_t order_clamp(input pss_lvl_t lvl);
		pss_lvl_t res;
		res = lvl;
		if (!res.batt) begin
			res.io = 1'b0;
		end
		if (!res.io) begin
			res.en = 1'b0;
		end
		if (!res.en) begin
			res.rstl = 1'b0;
		end
		return res;
	endfunction

	// guarded levels ahead of the output flops
	always_comb begin
		raw_lvl.batt = nxt_batt;
		raw_lvl.io   = nxt_io;
		raw_lvl.en   = nxt_en;
		raw_lvl.rstl = nxt_rstl;
		grd_lvl      = order_clamp(raw_lvl);
	end

	// sequencing decisions
	always_comb begin
		nxt_state = state_ff;
		nxt_batt  = batt_ff;
		nxt_io    = io_ff;
		nxt_en    = en_ff;
		nxt_rstl  = rstl_ff;
		tmr_start = 1'b0;
		case (state_ff)
			pss_pkg::PSS_HS_OFF: begin
				nxt_rstl = 1'b0;
				nxt_en   = 1'b0;
				if (power_on_in) begin
					nxt_batt  = 1'b1;
					nxt_state = pss_pkg::PSS_HS_BATT;
				end
			end
			pss_pkg::PSS_HS_BATT: begin
				nxt_io    = 1'b1;
				nxt_state = pss_pkg::PSS_HS_IO;
			end
			pss_pkg::PSS_HS_IO: begin
				nxt_en    = 1'b1;
				tmr_start = 1'b1;
				nxt_state = pss_pkg::PSS_HS_SETTLE;
			end
			pss_pkg::PSS_HS_SETTLE: begin
				if (!power_on_in) begin
					nxt_en    = 1'b0;
					nxt_state = pss_pkg::PSS_HS_DOWN_CORE;
				end else if (tmr_done) begin
					nxt_rstl  = 1'b1;
					nxt_state = pss_pkg::PSS_HS_RUN;
				end
			end
			pss_pkg::PSS_HS_RUN: begin
				if (!power_on_in) begin
					nxt_en    = 1'b0;
					nxt_rstl  = 1'b0;
					nxt_state = pss_pkg::PSS_HS_DOWN_CORE;
				end
			end
			pss_pkg::PSS_HS_DOWN_CORE: begin
				nxt_rstl  = 1'b0;
				nxt_io    = 1'b0;
				nxt_state = pss_pkg::PSS_HS_DOWN_IO;
			end
			pss_pkg::PSS_HS_DOWN_IO: begin
				nxt_batt  = 1'b0;
				nxt_state = pss_pkg::PSS_HS_OFF;
			end
			default: begin
				nxt_state = pss_pkg::PSS_HS_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			state_ff <= pss_pkg::PSS_HS_OFF;
			batt_ff  <= 1'b0;
			io_ff    <= 1'b0;
			en_ff    <= 1'b0;
			rstl_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			batt_ff  <= grd_lvl.batt;
			io_ff    <= grd_lvl.io;
			en_ff    <= grd_lvl.en;
			rstl_ff  <= grd_lvl.rstl;
		end
	end

	// running flag group
	// drops on the same edge as enable and reset on power down
	// run only while held up
	always_comb begin
		nxt_run = 1'b0;
		if (state_ff == pss_pkg::PSS_HS_RUN) begin
			nxt_run = power_on_in;
		end
	end

	// running flag register
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			run_ff <= 1'b0;
		end else begin
			run_ff <= nxt_run;
		end
	end

	// link drive
	assign link.battery_supply    = batt_ff;
	assign link.io_supply         = io_ff;
	assign link.core_power_enable = en_ff;
	assign link.hard_reset_low    = rstl_ff;
	assign running_out            = run_ff;
endmodule

// ---- pss_pkg.sv ----
// package of shared constants and types for the power sequence block
package pss_pkg;
	localparam int unsigned CLK_HZ          = 10000000;
	localparam int unsigned XO_SETTLE_MS    = 5;
	localparam int unsigned XO_SETTLE_CYC   = (CLK_HZ / 1000) * XO_SETTLE_MS;
	localparam int unsigned STEP_GAP_MS     = 0;
	localparam int unsigned STEP_GAP_CYC    = 1;
	localparam int unsigned PIN_COUNT       = 8;
	localparam int unsigned CNT_WIDTH       = 20;
	// pin states of the device side
	typedef enum logic [1:0] {
		PSS_PIN_OFF,
		PSS_PIN_RESET,
		PSS_PIN_DEFAULT,
		PSS_PIN_PROG
	} pss_pin_state_t;
	// host sequencer states
	typedef enum logic [2:0] {
		PSS_HS_OFF,
		PSS_HS_BATT,
		PSS_HS_IO,
		PSS_HS_SETTLE,
		PSS_HS_RUN,
		PSS_HS_DOWN_CORE,
		PSS_HS_DOWN_IO
	} pss_host_state_t;
endpackage

// ---- pss_link_if.sv ----
// interface joining the host sequencer and the device pin controller
`timescale 1ns/100ps
interface pss_link_if;
	logic battery_supply;
	logic io_supply;
	logic core_power_enable;
	logic hard_reset_low;
	modport host (
		output battery_supply,
		output io_supply,
		output core_power_enable,
		output hard_reset_low
	);
	modport device (
		input  battery_supply,
		input  io_supply,
		input  core_power_enable,
		input  hard_reset_low
	);
endinterface

// ---- pss_delay_timer.sv ----
// one-shot cycle counter used for the settle delay
`timescale 1ns/100ps
module pss_delay_timer #(
	parameter int unsigned WIDTH = 20
) (
	input  wire logic             ref_clk_in,   // system clock
	input  wire logic             rst_b_in,     // sync reset, low
	input  wire logic             start_in,     // load count
	input  wire logic [WIDTH-1:0] load_in,      // cycles to wait
	output logic                  done_out      // count reached zero
);
	logic [WIDTH-1:0] cnt_ff;
	logic [WIDTH-1:0] nxt_cnt;
	logic             done_ff;
	logic             nxt_done;

	// count down after a load
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_done = done_ff;
		if (start_in) begin
			nxt_cnt  = load_in;
			nxt_done = 1'b0;
		end else if (cnt_ff != '0) begin
			nxt_cnt  = cnt_ff - 1'b1;
			nxt_done = (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end

	// register stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			cnt_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done_out = done_ff;
endmodule

// ---- pss_dev_pins.sv ----
// device end: digital pin driver, input buffer and pull control per power state
`timescale 1ns/100ps
module pss_dev_pins #(
	parameter int unsigned PINS = pss_pkg::PIN_COUNT
) (
	input  wire logic            ref_clk_in,      // system clock
	input  wire logic            rst_b_in,        // sync reset, low
	input  wire logic            fw_config_in,    // firmware has programmed pins
	input  wire logic [PINS-1:0] fw_drive_en_in,  // firmware output enables
	input  wire logic [PINS-1:0] fw_pull_en_in,   // firmware pull enables
	output logic [PINS-1:0]      out_en_out,      // output driver enable
	output logic [PINS-1:0]      in_en_out,       // input buffer enable
	output logic [PINS-1:0]      pull_en_out,     // 96k pull enable
	output logic [1:0]           pin_state_out,   // current pin state
	pss_link_if.device           link             // link from the host
);
	pss_pkg::pss_pin_state_t state_ff;
	pss_pkg::pss_pin_state_t nxt_state;
	logic [PINS-1:0] oe_ff;
	logic [PINS-1:0] ie_ff;
	logic [PINS-1:0] pe_ff;
	logic [PINS-1:0] nxt_oe;
	logic [PINS-1:0] nxt_ie;
	logic [PINS-1:0] nxt_pe;
	logic            powered;

	assign powered = link.io_supply & link.core_power_enable;

	// state from link levels and firmware flag
	always_comb begin
		nxt_state = state_ff;
		nxt_oe    = '0;
		nxt_ie    = '0;
		nxt_pe    = '0;
		if (!powered) begin
			nxt_state = pss_pkg::PSS_PIN_OFF;
		end else if (!link.hard_reset_low) begin
			nxt_state = pss_pkg::PSS_PIN_RESET;
		end else if (fw_config_in) begin
			nxt_state = pss_pkg::PSS_PIN_PROG;
		end else if (state_ff != pss_pkg::PSS_PIN_PROG) begin
			nxt_state = pss_pkg::PSS_PIN_DEFAULT;
		end
		case (nxt_state)
			pss_pkg::PSS_PIN_OFF: begin
				nxt_oe = '0;
			end
			pss_pkg::PSS_PIN_RESET: begin
				nxt_pe = '1;
			end
			pss_pkg::PSS_PIN_DEFAULT: begin
				nxt_ie = '1;
				nxt_pe = '1;
			end
			pss_pkg::PSS_PIN_PROG: begin
				nxt_oe = fw_drive_en_in;
				nxt_ie = ~fw_drive_en_in;
				nxt_pe = fw_pull_en_in;
			end
			default: begin
				nxt_oe = '0;
			end
		endcase
	end

	// register stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			state_ff <= pss_pkg::PSS_PIN_OFF;
			oe_ff    <= '0;
			ie_ff    <= '0;
			pe_ff    <= '0;
		end else begin
			state_ff <= nxt_state;
			oe_ff    <= nxt_oe;
			ie_ff    <= nxt_ie;
			pe_ff    <= nxt_pe;
		end
	end

	assign out_en_out    = oe_ff;
	assign in_en_out     = ie_ff;
	assign pull_en_out   = pe_ff;
	assign pin_state_out = state_ff;
endmodule

// ---- pss_link_assertions.sv ----
// checker for the power sequence link and pin states
`timescale 1ns/100ps
module pss_link_assertions #(
	parameter int SETTLE = 20
) (
	input wire logic       ref_clk_in,        // system clock
	input wire logic       rst_b_in,          // sync reset, low
	input wire logic       battery_supply,    // battery rail
	input wire logic       io_supply,         // io rail
	input wire logic       core_power_enable, // core enable
	input wire logic       hard_reset_low,    // hard reset, low
	input wire logic [7:0] out_en_out,        // output drivers
	input wire logic [7:0] in_en_out,         // input buffers
	input wire logic [7:0] pull_en_out,       // pull enables
	input wire logic [1:0] pin_state_out      // pin state
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// link order, settle and power down
	chk_io_after_batt: assert property ($rose(io_supply) |-> $past(battery_supply))
		else $error("io rose before battery");
	chk_en_after_io: assert property ($rose(core_power_enable) |-> $past(io_supply))
		else $error("enable rose before io");
	chk_settle_hold: assert property ($rose(core_power_enable) |->
		!hard_reset_low throughout (##SETTLE 1)) else $error("reset released early");
	chk_en_reset_fall: assert property ($fell(core_power_enable) |-> !hard_reset_low)
		else $error("enable fell without reset");
	chk_io_fall_last: assert property ($fell(io_supply) |->
		$past(!core_power_enable && !hard_reset_low)) else $error("io fell too early");
	chk_batt_fall_last: assert property ($fell(battery_supply) |-> !io_supply)
		else $error("battery fell before io");
	chk_reset_while_off: assert property (!core_power_enable |-> !hard_reset_low)
		else $error("reset high while core off");
	// pin states follow the link
	chk_off_pins: assert property (!core_power_enable |=>
		!(|{out_en_out, in_en_out, pull_en_out})) else $error("pins live while off");
	chk_reset_pins: assert property (core_power_enable && !hard_reset_low |=>
		pull_en_out == 8'hFF && !(|{out_en_out, in_en_out})) else $error("bad reset pins");
	chk_default_pins: assert property ($rose(hard_reset_low) |=> pin_state_out == 2'h2
		&& out_en_out == 8'h00 && (in_en_out & pull_en_out) == 8'hFF) else $error("bad default");
	chk_prog_pins: assert property (pin_state_out == 2'h3 |-> in_en_out == ~out_en_out)
		else $error("input not opposite output");
	cover property ($rose(hard_reset_low));
	cover property (pin_state_out == 2'h3);
	cover property ($fell(battery_supply));
endmodule

// ---- pss_power_sequence_tb.sv ----
// self-checking bench for the host sequencer and device pins
`timescale 1ns/100ps
module pss_power_sequence_tb;
	localparam int SETTLE = 20;
	typedef struct packed {
		logic [1:0] st;
		logic [7:0] oe;
		logic [7:0] ie;
		logic [7:0] pe;
	} pss_note_t;
	logic       ref_clk_in;
	logic       rst_b_in;
	logic       power_on_in;
	logic       running_out;
	logic       fw_config_in;
	logic [7:0] fw_drive_en_in;
	logic [7:0] fw_pull_en_in;
	logic [7:0] out_en_out;
	logic [7:0] in_en_out;
	logic [7:0] pull_en_out;
	logic [1:0] pin_state_out;
	logic [1:0] last_st;
	logic [7:0] rnd;
	int         failures;
	int         compares;
	int         n;
	pss_note_t  notes[$];
	pss_note_t  nt;
	pss_link_if link();
	pss_host_seq #(.SETTLE_CYC(SETTLE)) i_pss_host_seq (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .power_on_in(power_on_in), .running_out(running_out), .link(link));
	pss_dev_pins i_pss_dev_pins (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.fw_config_in(fw_config_in), .fw_drive_en_in(fw_drive_en_in),
		.fw_pull_en_in(fw_pull_en_in), .out_en_out(out_en_out), .in_en_out(in_en_out),
		.pull_en_out(pull_en_out), .pin_state_out(pin_state_out), .link(link));
	pss_link_assertions #(.SETTLE(SETTLE)) i_pss_link_assertions (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .battery_supply(link.battery_supply), .io_supply(link.io_supply),
		.core_power_enable(link.core_power_enable), .hard_reset_low(link.hard_reset_low),
		.out_en_out(out_en_out), .in_en_out(in_en_out), .pull_en_out(pull_en_out),
		.pin_state_out(pin_state_out));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic step();
		@(posedge ref_clk_in);
		#10;
	endtask
	task automatic note(input logic [1:0] s, input logic [7:0] o, input logic [7:0] i,
		input logic [7:0] p);
		notes.push_back({s, o, i, p});
	endtask
	// bounded wait for a pin state
	task automatic wait_state(input logic [1:0] s);
		n = 0;
		while (pin_state_out !== s && n < 200) begin
			step();
			n++;
		end
		if (n == 200) begin
			failures++;
			print_verdict();
		end
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// compare each new pin state with the oldest note
	always @(negedge ref_clk_in) begin
		if (rst_b_in && pin_state_out !== last_st) begin
			nt = (notes.size() > 0) ? notes.pop_front() : '1;
			check("state", {6'h00, pin_state_out}, {6'h00, nt.st});
			check("drivers", out_en_out, nt.oe);
			check("inputs", in_en_out, nt.ie);
			check("pulls", pull_en_out, nt.pe);
			last_st = pin_state_out;
		end
	end
	initial begin
		rst_b_in = 1'b0;
		power_on_in = 1'b0;
		fw_config_in = 1'b0;
		fw_drive_en_in = 8'h00;
		fw_pull_en_in = 8'h00;
		last_st = 2'h0;
		rnd = 8'h24;
		failures = 0;
		compares = 0;
		repeat (16) step();
		rst_b_in = 1'b1;
		// abort while the crystal settles
		note(2'h1, 8'h00, 8'h00, 8'hFF);
		note(2'h0, 8'h00, 8'h00, 8'h00);
		power_on_in = 1'b1;
		wait_state(2'h1);
		repeat (5) step();
		power_on_in = 1'b0;
		wait_state(2'h0);
		// full power cycles with random firmware settings
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			fw_drive_en_in = rnd;
			rnd = lfsr(rnd);
			fw_pull_en_in = rnd;
			note(2'h1, 8'h00, 8'h00, 8'hFF);
			note(2'h2, 8'h00, 8'hFF, 8'hFF);
			note(2'h3, fw_drive_en_in, ~fw_drive_en_in, fw_pull_en_in);
			note(2'h0, 8'h00, 8'h00, 8'h00);
			power_on_in = 1'b1;
			n = 0;
			while (!link.core_power_enable && n < 10) begin
				step();
				n++;
			end
			if (n == 10) begin
				failures++;
				print_verdict();
			end
			n = 0;
			while (!link.hard_reset_low && n < 100) begin
				step();
				n++;
			end
			check("settle", n[7:0], 8'(SETTLE + 1));
			step();
			check("running", {7'h00, running_out}, 8'h01);
			wait_state(2'h2);
			fw_config_in = 1'b1;
			wait_state(2'h3);
			power_on_in = 1'b0;
			wait_state(2'h0);
			fw_config_in = 1'b0;
		end
		print_verdict();
	end
endmodule
